// ### mspm_pkg.sv
// package for the module status pin mux: offsets, field positions, types
package mspm_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFF_OEM_CONFIG_THREE = 8'h00;
    localparam logic [7:0] OFF_OEM_CONFIG_SIX = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;

    // oem_config_three fields
    localparam int CFG3_GPO_LEVEL = 0;
    localparam int CFG3_GPO_PUSH_PULL = 1;
    localparam int CFG3_RXSEL_GPO = 4;
    localparam int CFG3_RST_MODE = 7;
    // oem_config_six fields
    localparam int CFG6_TXSEL_RATE = 2;
    localparam int CFG6_LOS_POL = 3;
    // control byte fields
    localparam int CTL_RST_CMD_LSB = 0;
    localparam int CTL_SOFT_RX_RATE = 3;
    localparam int CTL_SOFT_TX_RATE = 4;
    localparam int CTL_GP_OUT = 5;
    // status fields
    localparam int ST_LOSS = 0;
    localparam int ST_TX_RATE_IN = 1;
    localparam int ST_RX_RATE_IN = 2;
    localparam int ST_RST_BUSY = 3;
    // interrupt event fields
    localparam int EV_LOSS_CHANGE = 0;
    localparam int EV_RST_DONE = 1;
    localparam int EV_RATE_CHANGE = 2;
    localparam int EV_W = 3;

    // reset values
    localparam logic [7:0] RST_CFG3 = 8'h00;
    localparam logic [7:0] RST_CFG6 = 8'h00;
    localparam logic [7:0] RST_CTL = 8'h00;
    // the loss line is pulled up, so its idle level is high
    localparam logic RST_LOSS_PREV = 1'b1;

    // reset pulse width: 8 clocks per unit of the 3-bit command
    localparam int PULSE_UNIT_CYCLES = 8;
    localparam logic [6:0] PULSE_CNT_W0 = 7'h00;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_PULSE = 2'b01
    } mspm_rst_e;

    typedef struct packed {
        logic [7:0] cfg3;
        logic [7:0] cfg6;
        logic [7:0] ctl;
        logic [EV_W-1:0] int_st;
        logic [EV_W-1:0] int_mask;
        mspm_rst_e rst_st;
        logic [6:0] rst_cnt;
        logic loss_prev;
        logic [1:0] rate_prev;
        logic los_pin_oe;
        logic rate_pin_oe;
        logic rate_pin_o;
        logic qg_pin_oe;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mspm_state_s;

endpackage : mspm_pkg

// ### mspm_top.sv
// module status pin mux: three open-drain status and rate pins behind apb, the rx rate pin push-pull in general output mode when config three bit 1 is set
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - config three bit 7 picks general output or pulsed active-low reset
// - in reset mode, control bits [2:0] start and size reset pulses
// - config six bit 2 clear: shared pin shows loss of received signal
// - config six bit 3 sets loss output polarity for normal operation
// - loss output deasserts when received power exceeds loss threshold
// - loss status bit follows the real pin level, wire-or included
// - config six bit 2 set: shared pin carries transmit rate select
// - transmit rate output is soft tx rate bit or tx rate input
// - config three bit 4 clear: rx rate out, open-drain, soft or input
// - config three bit 4 set: pin is general output from config bits
// - tx rate status bit mirrors the tx rate select input pin
// - rx rate status bit mirrors the rx rate select input pin
module mspm_top
    import mspm_pkg::*;
#(
    parameter int PULSE_UNIT = PULSE_UNIT_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator result: received power above loss threshold
    input wire logic rx_power_above_thr,
    // rate select inputs
    input wire logic tx_rate_sel_in,
    input wire logic rx_rate_sel_in,
    // loss / tx rate shared open-drain pin
    input wire logic rx_signal_loss_in,
    output logic rx_signal_loss_out,
    output logic rx_signal_loss_oe,
    // rx rate / general output pin
    output logic rx_rate_sel_out,
    output logic rx_rate_sel_oe,
    // reset or general output open-drain pin
    output logic reset_or_gp_out_pin,
    output logic reset_or_gp_oe,
    // interrupt
    output logic irq
);

    mspm_state_s s_q;
    mspm_state_s s_d;

    logic wr_en;
    logic rd_en;
    logic loss_active;
    logic [1:0] rate_now;
    logic [EV_W-1:0] ev;
    logic [6:0] pulse_len;

    always_comb begin
        s_d = s_q;
        wr_en = psel && penable && pwrite && !s_q.pready;
        rd_en = psel && penable && !pwrite && !s_q.pready;
        // loss asserted while power is not above threshold
        loss_active = !rx_power_above_thr;
        rate_now = {tx_rate_sel_in, rx_rate_sel_in};
        pulse_len = 7'(PULSE_UNIT) * {4'h0, s_q.ctl[CTL_RST_CMD_LSB +: 3]};
        ev = '0;

        // open-drain drive: oe high pulls the wire low
        if (s_q.cfg6[CFG6_TXSEL_RATE]) begin
            // rate high means release the line
            s_d.los_pin_oe = !(s_q.ctl[CTL_SOFT_TX_RATE]
                               | tx_rate_sel_in);
        end else if (s_q.cfg6[CFG6_LOS_POL]) begin
            // polarity 1: normal is released high, loss pulls low
            s_d.los_pin_oe = loss_active;
        end else begin
            // polarity 0: normal is pulled low, loss releases high
            s_d.los_pin_oe = !loss_active;
        end

        if (s_q.cfg3[CFG3_RXSEL_GPO]) begin
            s_d.rate_pin_o = s_q.cfg3[CFG3_GPO_LEVEL];
            s_d.rate_pin_oe = s_q.cfg3[CFG3_GPO_PUSH_PULL]
                              | !s_q.cfg3[CFG3_GPO_LEVEL];
        end else begin
            s_d.rate_pin_o = 1'b0;
            s_d.rate_pin_oe = !(s_q.ctl[CTL_SOFT_RX_RATE]
                                | rx_rate_sel_in);
        end

        // reset pulse generator
        case (s_q.rst_st)
            RS_IDLE: begin
                s_d.qg_pin_oe = s_q.cfg3[CFG3_RST_MODE] ? 1'b0
                                : !s_q.ctl[CTL_GP_OUT];
                if (s_q.cfg3[CFG3_RST_MODE] && pulse_len != PULSE_CNT_W0) begin
                    s_d.rst_st = RS_PULSE;
                    s_d.rst_cnt = pulse_len;
                    s_d.qg_pin_oe = 1'b1;
                end
            end
            RS_PULSE: begin
                s_d.rst_cnt = s_q.rst_cnt - 7'h01;
                if (s_q.rst_cnt == 7'h01 || !s_q.cfg3[CFG3_RST_MODE]) begin
                    s_d.rst_st = RS_IDLE;
                    // an abort hands the pin straight back to the gp level
                    s_d.qg_pin_oe = s_q.cfg3[CFG3_RST_MODE] ? 1'b0
                                    : !s_q.ctl[CTL_GP_OUT];
                    // the command clears itself so one write gives one pulse
                    s_d.ctl[CTL_RST_CMD_LSB +: 3] = 3'h0;
                    ev[EV_RST_DONE] = 1'b1;
                end
            end
            default: begin
                s_d.rst_st = RS_IDLE;
                s_d.qg_pin_oe = 1'b0;
            end
        endcase

        s_d.loss_prev = rx_signal_loss_in;
        s_d.rate_prev = rate_now;
        ev[EV_LOSS_CHANGE] = rx_signal_loss_in != s_q.loss_prev;
        ev[EV_RATE_CHANGE] = rate_now != s_q.rate_prev;

        // apb: one wait state, pready pulses on the access cycle after
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        if (wr_en) begin
            case (paddr)
                OFF_OEM_CONFIG_THREE: s_d.cfg3 = pwdata[7:0];
                OFF_OEM_CONFIG_SIX: s_d.cfg6 = pwdata[7:0];
                OFF_CONTROL: s_d.ctl = pwdata[7:0];
                OFF_INT_STATUS: s_d.int_st = s_q.int_st & ~pwdata[EV_W-1:0];
                OFF_INT_MASK: s_d.int_mask = pwdata[EV_W-1:0];
                OFF_STATUS: ;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        // set wins over a write-one-to-clear in the same cycle
        s_d.int_st = s_d.int_st | ev;
        if (rd_en) begin
            s_d.prdata = '0;
            case (paddr)
                OFF_OEM_CONFIG_THREE: s_d.prdata[7:0] = s_q.cfg3;
                OFF_OEM_CONFIG_SIX: s_d.prdata[7:0] = s_q.cfg6;
                OFF_CONTROL: s_d.prdata[7:0] = s_q.ctl;
                OFF_STATUS: begin
                    // pin level read back, so a wire-or driver shows too
                    s_d.prdata[ST_LOSS] = rx_signal_loss_in;
                    s_d.prdata[ST_TX_RATE_IN] = tx_rate_sel_in;
                    s_d.prdata[ST_RX_RATE_IN] = rx_rate_sel_in;
                    s_d.prdata[ST_RST_BUSY] = s_q.rst_st == RS_PULSE;
                end
                OFF_INT_STATUS: s_d.prdata[EV_W-1:0] = s_q.int_st;
                OFF_INT_MASK: s_d.prdata[EV_W-1:0] = s_q.int_mask;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        s_d.irq = |(s_d.int_st & s_d.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.cfg3 <= RST_CFG3;
            s_q.cfg6 <= RST_CFG6;
            s_q.ctl <= RST_CTL;
            s_q.rst_st <= RS_IDLE;
            // a zero here would log a false loss edge right after reset
            s_q.loss_prev <= RST_LOSS_PREV;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign rx_signal_loss_out = 1'b0;
    assign rx_signal_loss_oe = s_q.los_pin_oe;
    assign rx_rate_sel_out = s_q.rate_pin_o;
    assign rx_rate_sel_oe = s_q.rate_pin_oe;
    assign reset_or_gp_out_pin = 1'b0;
    assign reset_or_gp_oe = s_q.qg_pin_oe;
    assign irq = s_q.irq;

endmodule : mspm_top

// ### mspm_host.sv
// host side of the module status pins: pulled-up wire-or loss line
`timescale 1ns/100ps
module mspm_host (
    // device enable and an external open-drain pull on the same wire
    input wire logic loss_oe,
    input wire logic ext_low,
    // resulting wire level, high through the host pull-up when released
    output logic wire_lvl
);
    assign wire_lvl = !(loss_oe || ext_low);
endmodule : mspm_host

// ### mspm_top_chk.sv
// port assertions for the module status pin mux
`timescale 1ns/100ps
module mspm_chk
    import mspm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // pins
    input wire logic rx_power_above_thr,
    input wire logic tx_rate_sel_in,
    input wire logic rx_rate_sel_in,
    input wire logic rx_signal_loss_out,
    input wire logic rx_signal_loss_oe,
    input wire logic rx_rate_sel_out,
    input wire logic rx_rate_sel_oe,
    input wire logic reset_or_gp_out_pin,
    input wire logic reset_or_gp_oe
);
    // low through the edge that releases reset: the design still sits in
    // reset there, while the shadows already look ready
    logic live_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end
    // shadow copies of the config bytes; pulse bits of control are not used
    logic [7:0] c3_q, c6_q, ct_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c3_q <= 8'h00;
            c6_q <= 8'h00;
            ct_q <= 8'h00;
        end else if (psel && penable && pwrite && !pready) begin
            if (paddr == OFF_OEM_CONFIG_THREE) c3_q <= pwdata[7:0];
            if (paddr == OFF_OEM_CONFIG_SIX) c6_q <= pwdata[7:0];
            if (paddr == OFF_CONTROL) ct_q <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !live_q);
    sequence wait_s; psel && penable && !pready; endsequence
    sequence done_s; pready ##1 !pready; endsequence
    one_wait_a: assert property (wait_s |=> done_s)
        else $error("apb answer not after one wait");
    bad_addr_a: assert property (pready && paddr > OFF_INT_MASK |-> pslverr)
        else $error("unmapped access without error");
    pins_data_a: assert property (
        !rx_signal_loss_out && !reset_or_gp_out_pin)
        else $error("open-drain data not low");
    loss_pol_a: assert property (
        !c6_q[2] |=> rx_signal_loss_oe ==
        ($past(c6_q[3]) ^ $past(rx_power_above_thr)))
        else $error("loss pin");
    tx_rate_a: assert property (
        c6_q[2] |=> rx_signal_loss_oe ==
        !($past(ct_q[4]) || $past(tx_rate_sel_in)))
        else $error("tx rate pin");
    rx_rate_a: assert property (
        !c3_q[4] |=> !rx_rate_sel_out &&
        rx_rate_sel_oe == !($past(ct_q[3]) || $past(rx_rate_sel_in)))
        else $error("rx rate pin");
    gpo_mode_a: assert property (
        c3_q[4] |=> rx_rate_sel_out == $past(c3_q[0]) &&
        rx_rate_sel_oe == ($past(c3_q[1]) || !$past(c3_q[0])))
        else $error("general output pin");
    gp_level_a: assert property (
        !c3_q[7] |=> reset_or_gp_oe == !$past(ct_q[5]))
        else $error("gp level pin");
endmodule : mspm_chk
bind mspm_top mspm_chk chk_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pready(pready),
    .pslverr(pslverr),
    .paddr(paddr),
    .pwdata(pwdata),
    .rx_power_above_thr(rx_power_above_thr),
    .tx_rate_sel_in(tx_rate_sel_in),
    .rx_rate_sel_in(rx_rate_sel_in),
    .rx_signal_loss_out(rx_signal_loss_out),
    .rx_signal_loss_oe(rx_signal_loss_oe),
    .rx_rate_sel_out(rx_rate_sel_out),
    .rx_rate_sel_oe(rx_rate_sel_oe),
    .reset_or_gp_out_pin(reset_or_gp_out_pin),
    .reset_or_gp_oe(reset_or_gp_oe)
);

// ### mspm_top_tb.sv
// self-checking bench for the module status pin mux
`timescale 1ns/100ps
module mspm_top_tb;
    import mspm_pkg::*;
    localparam int PU = 2;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ext_low = 0, rx_signal_loss_in;
    logic rx_power_above_thr = 0, tx_rate_sel_in = 0, rx_rate_sel_in = 0;
    logic rx_signal_loss_out, rx_signal_loss_oe, rx_rate_sel_out;
    logic rx_rate_sel_oe, reset_or_gp_out_pin, reset_or_gp_oe, irq;
    int errors = 0, n_tests = 0, qcnt = 0;
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) if (reset_or_gp_oe === 1'b1) qcnt++;
    mspm_top #(.PULSE_UNIT(PU)) dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rx_power_above_thr(rx_power_above_thr),
        .tx_rate_sel_in(tx_rate_sel_in),
        .rx_rate_sel_in(rx_rate_sel_in),
        .rx_signal_loss_in(rx_signal_loss_in),
        .rx_signal_loss_out(rx_signal_loss_out),
        .rx_signal_loss_oe(rx_signal_loss_oe),
        .rx_rate_sel_out(rx_rate_sel_out),
        .rx_rate_sel_oe(rx_rate_sel_oe),
        .reset_or_gp_out_pin(reset_or_gp_out_pin),
        .reset_or_gp_oe(reset_or_gp_oe),
        .irq(irq)
    );
    mspm_host host_u (.loss_oe(rx_signal_loss_oe), .ext_low(ext_low),
        .wire_lvl(rx_signal_loss_in));
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // entered just after a rising edge; three idle edges after each transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int k;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        repeat (3) @(posedge pclk);
    endtask : xfer
    task automatic s_loss;
        for (int i = 0; i < 4; i++) begin
            xfer(1, OFF_OEM_CONFIG_SIX, {i[1], 3'h0});
            rx_power_above_thr <= i[0];
            xfer(0, OFF_STATUS, 0);
            chk("loss_oe", rx_signal_loss_oe,
                i[1] ^ i[0]);
        end
        ext_low <= 1;
        xfer(0, OFF_STATUS, 0);
        chk("loss_wire_or", rd[ST_LOSS], 0);
        ext_low <= 0;
        xfer(0, OFF_STATUS, 0);
        chk("loss_released", rd[ST_LOSS], 1);
    endtask : s_loss
    task automatic s_rate;
        xfer(1, OFF_OEM_CONFIG_SIX, 32'h4);
        for (int i = 0; i < 4; i++) begin
            xfer(1, OFF_CONTROL, {i[0], i[0], 3'h0});
            tx_rate_sel_in <= i[1];
            rx_rate_sel_in <= ~i[1];
            xfer(0, OFF_STATUS, 0);
            chk("tx_rate_oe", rx_signal_loss_oe,
                !(i[0] | i[1]));
            chk("rx_rate_oe", rx_rate_sel_oe, !(i[0] | !i[1]));
            chk("rate_st", rd[2:1], {~i[1], i[1]});
            xfer(1, OFF_OEM_CONFIG_THREE, 32'h10 | i);
            chk("gpo", {rx_rate_sel_out, rx_rate_sel_oe},
                {i[0], i[1] | !i[0]});
            xfer(1, OFF_OEM_CONFIG_THREE, 0);
        end
    endtask : s_rate
    task automatic s_pulse;
        xfer(1, OFF_CONTROL, 32'h20);
        chk("gp_high", reset_or_gp_oe, 0);
        xfer(1, OFF_INT_STATUS, 32'h7);
        xfer(1, OFF_INT_MASK, 32'h2);
        xfer(1, OFF_OEM_CONFIG_THREE, 32'h80);
        qcnt = 0;
        xfer(1, OFF_CONTROL, 32'h27);
        // the longest command leaves room to read busy mid-pulse
        xfer(0, OFF_STATUS, 0);
        chk("pulse_busy", rd[ST_RST_BUSY], 1);
        repeat (20) @(posedge pclk);
        chk("pulse_len", qcnt, PU * 7);
        chk("irq_on", irq, 1);
        xfer(0, OFF_INT_STATUS, 0);
        chk("done_flag", rd[EV_RST_DONE], 1);
        xfer(0, OFF_CONTROL, 0);
        chk("cmd_cleared", rd[2:0], 0);
        xfer(1, OFF_INT_STATUS, 32'h2);
        chk("irq_off", irq, 0);
        xfer(0, 8'h40, 0);
        chk("unmapped", err, 1);
    endtask : s_pulse
    // reset lands in the middle of a pulse and must release the pin
    task automatic s_reset;
        xfer(1, OFF_CONTROL, 32'h07);
        chk("pulse_on", reset_or_gp_oe, 1);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        chk("rst_release", reset_or_gp_oe, 0);
        presetn <= 1;
        @(posedge pclk);
        xfer(0, OFF_OEM_CONFIG_THREE, 0);
        chk("cfg3_rst_again", rd, 0);
        xfer(0, OFF_CONTROL, 0);
        chk("ctl_rst_again", rd, 0);
    endtask : s_reset
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        xfer(0, OFF_OEM_CONFIG_THREE, 0);
        chk("cfg3_reset", rd, 0);
        xfer(0, OFF_INT_STATUS, 0);
        chk("no_false_edge", rd, 0);
        s_loss();
        s_rate();
        s_pulse();
        s_reset();
        give_verdict();
    end
endmodule : mspm_top_tb
